// ==== design/vdad_map.svh ====
`ifndef VDAD_MAP_SVH
`define VDAD_MAP_SVH

// parameter register addresses on the two register select inputs
`define VDAD_REG_STATUS    2'h0
`define VDAD_REG_POINTER   2'h2
`define VDAD_REG_SCROLL    2'h3
`define VDAD_REG_PAGE      2'h3

// parameter modes as held in the mode register
`define VDAD_MODE_SCROLL   3'h4
`define VDAD_MODE_POINTER  3'h5
`define VDAD_MODE_PAGE     3'h6

// field positions, reset values and wrap limits
`define VDAD_PAGE_P_BIT    2
`define VDAD_PAGE_V1_BIT   1
`define VDAD_PAGE_V0_BIT   0
`define VDAD_PAGE_RESET    3'h0
`define VDAD_SCROLL_RESET  8'h00
`define VDAD_SCROLL_MAX    8'hD1
`define VDAD_IMAGE_ROWS    9'h0D2
`define VDAD_LOW_WRAP      5'h1F

// bus clock timing
`define VDAD_CLK_NS        100
`define VDAD_E_PERIOD_NS   700
`define VDAD_Q_OFFSET_NS   175
`define VDAD_E_CYCLES      (`VDAD_E_PERIOD_NS / `VDAD_CLK_NS)
`define VDAD_Q_CYCLES      ((`VDAD_Q_OFFSET_NS + `VDAD_CLK_NS - 1) / `VDAD_CLK_NS)

`endif

// ==== design/vdad_pkg.sv ====
package vdad_pkg;

  // access sequencer, gray along idle-row-col-data and ack-write
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_ROW     = 3'h1,
    ST_COL     = 3'h3,
    ST_DATA    = 3'h2,
    ST_DMA_ACK = 3'h6,
    ST_DMA_WR  = 3'h7
  } vdad_state_t;

  // decoded memory page codes
  typedef enum logic [2:0] {
    PG_VIDEO0  = 3'h0,
    PG_VIDEO1  = 3'h1,
    PG_VIDEO2  = 3'h2,
    PG_SHARED  = 3'h3,
    PG_PROGRAM = 3'h4
  } vdad_page_t;

endpackage

// ==== design/vdad_fifo.sv ====
`timescale 1ns/1ps

module vdad_fifo import vdad_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             out_valid;
    logic [WIDTH-1:0] out_data;
  } vdad_fifo_state_t;

  vdad_fifo_state_t s, next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push, pop, load;

  // output register refills whenever it is empty or being taken
  always_comb begin
    next_s = s;
    push   = in_valid_in && in_ready_out;
    load   = (s.count != '0) && (!s.out_valid || out_ready_in);
    pop    = s.out_valid && out_ready_in;
    if (load) begin
      next_s.out_data = mem[s.rd_ptr];
      next_s.rd_ptr   = s.rd_ptr + 1'b1;
    end
    if (push) begin
      next_s.wr_ptr = s.wr_ptr + 1'b1;
    end
    next_s.out_valid = load || (s.out_valid && !out_ready_in);
    next_s.count     = s.count + (AW+1)'(push) - (AW+1)'(load);
  end

  // full counts the array only; the output stage is one extra slot
  assign in_ready_out  = (s.count != (AW+1)'(DEPTH));
  assign out_valid_out = s.out_valid;
  assign out_data_out  = s.out_data;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // storage has no reset, only written entries are ever read
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[s.wr_ptr] <= in_data_in;
    end
  end

endmodule

// ==== design/vdad_bus_clock.sv ====
`timescale 1ns/1ps
`include "vdad_map.svh"

module vdad_bus_clock import vdad_pkg::*; (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic reset_n_in,
  // withhold request and phase pulses
  input  wire logic stall_in,
  output logic      hold_start_out,
  output logic      hold_end_out,
  output logic      e_rise_out,
  output logic      e_fall_out,
  // bus clocks
  output logic      e_clock_out,
  output logic      q_clock_out
);
  localparam logic [2:0] LAST  = 3'(`VDAD_E_CYCLES - 1);
  localparam logic [2:0] E_HI  = 3'(`VDAD_E_CYCLES - `VDAD_E_CYCLES / 2);
  localparam logic [2:0] Q_HI  = 3'(`VDAD_Q_CYCLES);
  localparam logic [2:0] Q_LO  = 3'(`VDAD_Q_CYCLES + `VDAD_E_CYCLES / 2);

  typedef struct packed {
    logic [2:0] cnt;
    logic       hold;
    logic       e;
    logic       q;
  } vdad_clk_state_t;

  vdad_clk_state_t s, next_s;

  // one whole period of E and Q is withheld per stall request
  always_comb begin
    next_s     = s;
    next_s.cnt = (s.cnt == LAST) ? 3'h0 : s.cnt + 3'h1;
    if (s.cnt == LAST) begin
      next_s.hold = stall_in && !s.hold;
    end
    next_s.e = !next_s.hold && (next_s.cnt >= E_HI);
    next_s.q = !next_s.hold && (next_s.cnt >= Q_HI) && (next_s.cnt < Q_LO);
  end

  assign hold_start_out = (s.cnt == LAST) && stall_in && !s.hold;
  assign hold_end_out   = (s.cnt == LAST) && s.hold;
  assign e_rise_out     = !s.hold && (s.cnt == E_HI - 3'h1);
  assign e_fall_out     = !s.hold && (s.cnt == LAST);
  assign e_clock_out    = s.e;
  assign q_clock_out    = s.q;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// ==== design/vdad_access.sv ====
`timescale 1ns/1ps
`include "vdad_map.svh"

module vdad_access import vdad_pkg::*; #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  // processor pins
  input  wire logic        memory_chip_select_n_in,
  input  wire logic        param_chip_select_n_in,
  input  wire logic [1:0]  reg_select_in,
  input  wire logic        read_not_write_in,
  input  wire logic        program_space_select_in,
  input  wire logic [2:0]  param_mode_in,
  // multiplexed bus
  input  wire logic [7:0]  muxed_addr_data_bus_in,
  output logic [7:0]       muxed_addr_data_bus_out,
  output logic [7:0]       muxed_addr_data_bus_oe_out,
  // external buffer enables
  output logic             row_addr_buffer_en_out,
  output logic             col_addr_buffer_en_out,
  output logic             data_buffer_en_out,
  // memory strobes and address
  output logic             row_strobe_n_out,
  output logic             video_col_strobe_lo_n_out,
  output logic             video_col_strobe_hi_n_out,
  output logic             program_col_strobe_n_out,
  output logic             write_strobe_n_out,
  output logic             output_enable_n_out,
  output logic [12:0]      dram_addr_out,
  // bus clocks
  output logic             e_clock_out,
  output logic             q_clock_out,
  // teletext link
  input  wire logic        dma_request_n_in,
  input  wire logic        link_clock_in,
  output logic             dma_ack_output_enable_n_out,
  output logic             dma_fifo_ready_out,
  // raster side
  input  wire logic        horiz_blank_in,
  input  wire logic [7:0]  graphics_line_in,
  output logic [7:0]       fetch_row_out
);
  typedef struct packed {
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic        link_prev;
    vdad_state_t state;
    logic [7:0]  scroll;
    logic [7:0]  upper;
    logic [4:0]  low;
    logic [2:0]  page;
    logic        stall;
    logic [7:0]  bus_out;
    logic [7:0]  bus_oe;
    logic        row_en;
    logic        col_en;
    logic        data_en;
    logic        ras_n;
    logic        cas_lo_n;
    logic        cas_hi_n;
    logic        program_col_strobe_n;
    logic        w_n;
    logic        oe_n;
    logic [12:0] addr;
    logic        ack_n;
    logic        pop;
    logic [7:0]  fetch_row;
  } vdad_state_s_t;

  vdad_state_s_t s, next_s;

  // synchronised pin views
  logic       mem_cs_n, par_cs_n, rw, a13, req_n, link_clk;
  logic [1:0] rsel;
  logic [7:0] bus_sync;
  // helper signals
  logic       e_rise, e_fall, hold_start, hold_end;
  logic       push, fifo_ready, fifo_valid;
  logic [7:0] fifo_data;
  logic       program_sel, reg_write, reg_read;
  logic [8:0] row_sum;
  logic [7:0] read_data;

  assign mem_cs_n = s.sync2[0];
  assign par_cs_n = s.sync2[1];
  assign rsel     = s.sync2[3:2];
  assign rw       = s.sync2[4];
  assign a13      = s.sync2[5];
  assign req_n    = s.sync2[6];
  assign link_clk = s.sync2[7];
  assign bus_sync = s.sync2[15:8];

  // byte taken on a falling link clock edge while the request is low
  assign push = s.link_prev && !link_clk && !req_n;

  vdad_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_in      (clock_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (bus_sync),
    .out_valid_out (fifo_valid),
    .out_ready_in  (s.pop),
    .out_data_out  (fifo_data)
  );

  vdad_bus_clock u_clk (
    .clock_in       (clock_in),
    .reset_n_in     (reset_n_in),
    .stall_in       (s.stall),
    .hold_start_out (hold_start),
    .hold_end_out   (hold_end),
    .e_rise_out     (e_rise),
    .e_fall_out     (e_fall),
    .e_clock_out    (e_clock_out),
    .q_clock_out    (q_clock_out)
  );

  // program space wins over the page bit; shared page still needs p
  assign program_sel = a13 || s.page[`VDAD_PAGE_P_BIT];

  // register writes fall on the end of e high; reads last all of e high
  assign reg_write = e_fall && !par_cs_n && !rw;
  assign reg_read  = !par_cs_n && rw && e_clock_out;

  // readback: pointer in mode 5, status page bits in any mode
  always_comb begin
    read_data = 8'h00;
    if (rsel == `VDAD_REG_POINTER && param_mode_in == `VDAD_MODE_POINTER) begin
      read_data = s.upper;
    end else if (rsel == `VDAD_REG_STATUS) begin
      read_data = {5'h00, s.page};
    end
  end

  // display row wraps modulo the image height
  always_comb begin
    row_sum = {1'b0, s.scroll} + {1'b0, graphics_line_in};
    if (row_sum >= `VDAD_IMAGE_ROWS) begin
      row_sum = row_sum - `VDAD_IMAGE_ROWS;
    end
  end

  always_comb begin
    next_s           = s;
    next_s.sync1     = {muxed_addr_data_bus_in, link_clock_in, dma_request_n_in,
                        program_space_select_in, read_not_write_in, reg_select_in,
                        param_chip_select_n_in, memory_chip_select_n_in};
    next_s.sync2     = s.sync1;
    next_s.link_prev = link_clk;
    next_s.pop       = 1'b0;
    next_s.fetch_row = row_sum[7:0];

    // parameter writes, decoded from mode and selects
    if (reg_write) begin
      if (param_mode_in == `VDAD_MODE_SCROLL && rsel == `VDAD_REG_SCROLL) begin
        next_s.scroll = bus_sync;
      end
      if (param_mode_in == `VDAD_MODE_PAGE && rsel == `VDAD_REG_PAGE) begin
        next_s.page = bus_sync[2:0];
      end
    end

    // register read drive, all eight lines, registered so one cycle behind e high
    next_s.bus_out = read_data;
    next_s.bus_oe  = reg_read ? 8'hFF : 8'h00;

    // default strobe levels, outputs of an idle sequencer
    next_s.row_en   = 1'b0;
    next_s.col_en   = 1'b0;
    next_s.data_en  = 1'b0;
    next_s.ras_n    = 1'b1;
    next_s.cas_lo_n = 1'b1;
    next_s.cas_hi_n = 1'b1;
    next_s.program_col_strobe_n   = 1'b1;
    next_s.w_n      = 1'b1;
    next_s.oe_n     = 1'b1;
    next_s.addr     = 13'h0000;
    next_s.ack_n    = 1'b1;

    case (s.state)
      ST_IDLE: begin
        if (e_rise && !mem_cs_n) begin
          next_s.state  = ST_ROW;
          next_s.row_en = 1'b1;
          next_s.ras_n  = 1'b0;
        end else if (e_fall && fifo_valid && mem_cs_n) begin
          next_s.state = ST_DMA_ACK;
          next_s.stall = 1'b1;
          next_s.ack_n = 1'b0;
        end
      end
      ST_ROW: begin
        // row address is on the bus from the outside buffers
        next_s.state  = ST_COL;
        next_s.ras_n  = 1'b0;
        next_s.col_en = 1'b1;
        next_s.bus_oe = 8'h60;
        if (program_sel) begin
          next_s.bus_out = {1'b0, a13, rsel[0], 5'h00};
          next_s.program_col_strobe_n  = 1'b0;
        end else begin
          next_s.bus_out  = {1'b0, s.page[`VDAD_PAGE_V1_BIT],
                             s.page[`VDAD_PAGE_V0_BIT], 5'h00};
          next_s.cas_lo_n = rsel[0];
          next_s.cas_hi_n = !rsel[0];
        end
      end
      ST_COL: begin
        next_s.state    = ST_DATA;
        next_s.ras_n    = 1'b0;
        next_s.cas_lo_n = s.cas_lo_n;
        next_s.cas_hi_n = s.cas_hi_n;
        next_s.program_col_strobe_n   = s.program_col_strobe_n;
        next_s.data_en  = 1'b1;
        next_s.w_n      = rw;
        next_s.oe_n     = !rw;
      end
      ST_DATA: begin
        // strobes hold until e falls; chip select lost ends partial
        if (e_fall || mem_cs_n) begin
          next_s.state = ST_IDLE;
        end else begin
          next_s.ras_n    = 1'b0;
          next_s.cas_lo_n = s.cas_lo_n;
          next_s.cas_hi_n = s.cas_hi_n;
          next_s.program_col_strobe_n   = s.program_col_strobe_n;
          next_s.data_en  = 1'b1;
          next_s.w_n      = s.w_n;
          next_s.oe_n     = s.oe_n;
        end
      end
      ST_DMA_ACK: begin
        next_s.ack_n = 1'b0;
        if (hold_start) begin
          next_s.state = ST_DMA_WR;
          next_s.stall = 1'b0;
        end
      end
      ST_DMA_WR: begin
        // page bits are not touched by the transfer
        next_s.ack_n    = 1'b0;
        next_s.ras_n    = 1'b0;
        next_s.cas_lo_n = 1'b0;
        next_s.w_n      = 1'b0;
        next_s.addr     = {s.upper, s.low};
        next_s.bus_out  = fifo_data;
        next_s.bus_oe   = 8'hFF;
        if (hold_end) begin
          next_s.state = ST_IDLE;
          next_s.pop   = 1'b1;
          next_s.low   = s.low + 5'h01;
          if (s.low == `VDAD_LOW_WRAP) begin
            next_s.upper = s.upper + 8'h01;
          end
        end
      end
      default: begin
        next_s.state = ST_IDLE;
        next_s.stall = 1'b0;
      end
    endcase

    // pointer write reloads latch and counter; blanking overrides
    if (reg_write && param_mode_in == `VDAD_MODE_POINTER && rsel == `VDAD_REG_POINTER) begin
      next_s.upper = bus_sync;
      next_s.low   = 5'h00;
    end
    if (horiz_blank_in) begin
      next_s.upper = 8'h00;
      next_s.low   = 5'h00;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s          <= '0;
      s.sync1    <= 16'h007F; // link clock idles low, no false edge
      s.sync2    <= 16'h007F;
      s.ras_n    <= 1'b1;
      s.cas_lo_n <= 1'b1;
      s.cas_hi_n <= 1'b1;
      s.program_col_strobe_n   <= 1'b1;
      s.w_n      <= 1'b1;
      s.oe_n     <= 1'b1;
      s.ack_n    <= 1'b1;
      s.scroll   <= `VDAD_SCROLL_RESET;
      s.page     <= `VDAD_PAGE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // every output is a flop of the state, handshake ready excepted
  assign muxed_addr_data_bus_out     = s.bus_out;
  assign muxed_addr_data_bus_oe_out  = s.bus_oe;
  assign row_addr_buffer_en_out      = s.row_en;
  assign col_addr_buffer_en_out      = s.col_en;
  assign data_buffer_en_out          = s.data_en;
  assign row_strobe_n_out            = s.ras_n;
  assign video_col_strobe_lo_n_out   = s.cas_lo_n;
  assign video_col_strobe_hi_n_out   = s.cas_hi_n;
  assign program_col_strobe_n_out    = s.program_col_strobe_n;
  assign write_strobe_n_out          = s.w_n;
  assign output_enable_n_out         = s.oe_n;
  assign dram_addr_out               = s.addr;
  assign dma_ack_output_enable_n_out = s.ack_n;
  assign dma_fifo_ready_out          = fifo_ready;
  assign fetch_row_out               = s.fetch_row;

endmodule

// ==== dv/vdad_access_monitor.sv ====
`timescale 1ns/1ps

module vdad_access_monitor #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic        clock_in,
  input wire logic        reset_n_in,
  // buffer enables and bus drive
  input wire logic [7:0]  muxed_addr_data_bus_oe_out,
  input wire logic        row_addr_buffer_en_out,
  input wire logic        col_addr_buffer_en_out,
  input wire logic        data_buffer_en_out,
  // strobes and address
  input wire logic        row_strobe_n_out,
  input wire logic        video_col_strobe_lo_n_out,
  input wire logic        video_col_strobe_hi_n_out,
  input wire logic        program_col_strobe_n_out,
  input wire logic        write_strobe_n_out,
  input wire logic        output_enable_n_out,
  input wire logic [12:0] dram_addr_out,
  // bus clocks and link
  input wire logic        e_clock_out,
  input wire logic        q_clock_out,
  input wire logic        dma_ack_output_enable_n_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  // column phase of a processor access
  sequence s_col_phase;
    col_addr_buffer_en_out && muxed_addr_data_bus_oe_out == 8'h60;
  endsequence
  // withheld bus clock period of a dma byte
  sequence s_dma_wr;
    !row_strobe_n_out && !video_col_strobe_lo_n_out && !e_clock_out && !q_clock_out;
  endsequence

  chk_col_ad_drive: assert property ($rose(col_addr_buffer_en_out) |-> s_col_phase)
    else $error("column phase without bus lines 5 and 6 driven");
  chk_row_first: assert property ($rose(col_addr_buffer_en_out) |->
                                  $past(!row_strobe_n_out))
    else $error("column phase without row strobe before it");
  chk_data_after: assert property ($rose(data_buffer_en_out) |->
                                   $past(col_addr_buffer_en_out))
    else $error("data enable not after column phase");
  chk_one_col: assert property ($onehot0({!video_col_strobe_lo_n_out,
                                !video_col_strobe_hi_n_out, !program_col_strobe_n_out}))
    else $error("more than one column strobe");
  chk_dma_write: assert property (!dma_ack_output_enable_n_out &&
                                  !write_strobe_n_out |-> s_dma_wr)
    else $error("dma write without row, column strobe or held clocks");
  chk_addr_only_dma: assert property (dram_addr_out != 13'h0000 |->
                                      !write_strobe_n_out && !dma_ack_output_enable_n_out)
    else $error("dma address outside a dma write");
  chk_e_high_len: assert property ($rose(e_clock_out) |->
                                   e_clock_out [*3] ##1 !e_clock_out)
    else $error("bus clock high phase not three cycles");
  chk_q_lead: assert property ($rose(q_clock_out) |-> ##2 $rose(e_clock_out))
    else $error("q not leading e by two cycles");
  chk_read_in_e: assert property (muxed_addr_data_bus_oe_out == 8'hFF &&
                                  dma_ack_output_enable_n_out |->
                                  e_clock_out || $past(e_clock_out))
    else $error("register read drive outside e high");
  chk_ack_bound: assert property ($fell(dma_ack_output_enable_n_out) |->
                                  ##[1:30] $rose(dma_ack_output_enable_n_out))
    else $error("dma acknowledge held too long");
  // outside row buffer must have had its turn just before the column one
  chk_row_en_first: assert property ($rose(col_addr_buffer_en_out) |->
                                     $past(row_addr_buffer_en_out) && !row_addr_buffer_en_out)
    else $error("column enable without row enable just before it");
  chk_three_strobes: assert property ($rose(data_buffer_en_out) |->
                                      !row_strobe_n_out &&
                                      (output_enable_n_out != write_strobe_n_out))
    else $error("data phase without row strobe and one of read or write strobe");
endmodule

bind vdad_access vdad_access_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) vdad_access_monitor_inst (.*);

// ==== dv/vdad_prefix_model.sv ====
`timescale 1ns/1ps

module vdad_prefix_model (
  // clock for start alignment
  input wire logic  clock_in,
  // link pins
  output logic       dma_request_n_out,
  output logic       link_clock_out,
  output logic       data_en_out,
  output logic [7:0] data_out
);
  // link clock stands low between bytes
  initial begin
    dma_request_n_out = 1'h1;
    link_clock_out = 1'h0;
    data_en_out = 1'h0;
    data_out = 8'h00;
  end

  // one byte per frame, taken on the falling link edge
  task automatic send(input logic [7:0] b);
    @(posedge clock_in);
    #1;
    dma_request_n_out = 1'h0;
    data_en_out = 1'h1;
    data_out = b;
    link_clock_out = 1'h1;
    #400;
    link_clock_out = 1'h0;
    #400;
    dma_request_n_out = 1'h1;
    data_en_out = 1'h0;
    data_out = ~b; // released lines must not look valid
  endtask
endmodule

// ==== dv/tb_vdad_access.sv ====
`timescale 1ns/1ps
`include "vdad_map.svh"

module tb_vdad_access;
  // design inputs
  logic       clock_in;
  logic       reset_n_in;
  logic       memory_chip_select_n_in = 1'h1;
  logic       param_chip_select_n_in  = 1'h1;
  logic [1:0] reg_select_in           = 2'h0;
  logic       read_not_write_in       = 1'h1;
  logic       program_space_select_in = 1'h0;
  logic [2:0] param_mode_in           = 3'h0;
  logic       horiz_blank_in          = 1'h0;
  logic [7:0] graphics_line_in        = 8'h00;
  wire logic [7:0] muxed_addr_data_bus_in;
  wire logic dma_request_n_in, link_clock_in;
  // design outputs
  wire logic [7:0] muxed_addr_data_bus_out, muxed_addr_data_bus_oe_out, fetch_row_out;
  wire logic row_addr_buffer_en_out, col_addr_buffer_en_out, data_buffer_en_out;
  wire logic row_strobe_n_out, video_col_strobe_lo_n_out, video_col_strobe_hi_n_out;
  wire logic program_col_strobe_n_out, write_strobe_n_out, output_enable_n_out;
  wire logic e_clock_out, q_clock_out, dma_ack_output_enable_n_out, dma_fifo_ready_out;
  wire logic [12:0] dram_addr_out;
  // bench state
  wire logic p_en;
  wire logic [7:0] p_data;
  logic [7:0] cpu_bus = 8'h00, junk = 8'hA3, ptr = 8'h00, s;
  logic [4:0] low = 5'h00;
  logic [31:0] seed = 32'h00000036, exp_q[$];
  logic cpu_en = 1'h0, mem_chk = 1'h1, rd, mm, dm, rd_q = 1'h0, mm_q = 1'h0, dm_q = 1'h0;
  int n_mismatch = 0, tests_run = 0;

  vdad_access vdad_access_inst (.*);
  vdad_prefix_model vdad_prefix_model_inst (.clock_in(clock_in),
    .dma_request_n_out(dma_request_n_in), .link_clock_out(link_clock_in),
    .data_en_out(p_en), .data_out(p_data));

  // undriven bus lines wander so a stale value never passes; the prefix
  // processor owns the lines for its frame, even across a strobe phase
  assign muxed_addr_data_bus_in = p_en ? p_data
    : (muxed_addr_data_bus_out & muxed_addr_data_bus_oe_out)
    | (~muxed_addr_data_bus_oe_out & (cpu_en ? cpu_bus : junk));
  always @(posedge clock_in) junk <= junk + 8'h5B;

  // clock and reset
  initial begin
    clock_in = 1'h0;
    forever #50 clock_in = ~clock_in;
  end
  initial begin
    reset_n_in = 1'h0;
    repeat (2) @(posedge clock_in);
    #1 reset_n_in = 1'h1;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic tick();
    @(posedge clock_in);
    #1;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic give_up();
    n_mismatch++;
    $display("unexpected at %0t: wait ran out", $time);
    final_report();
  endtask

  task automatic wait_e(input logic lvl);
    int i;
    for (i = 0; i < 40 && e_clock_out !== lvl; i++) tick();
    if (i == 40) give_up();
  endtask

  task automatic drain();
    int i;
    for (i = 0; i < 3000 && exp_q.size() != 0; i++) tick();
    if (i == 3000) give_up();
  endtask

  // one register access spanning a whole e period
  task automatic reg_acc(input logic [2:0] m, input logic [1:0] a, input logic r,
                         input logic [7:0] d);
    wait_e(1'h1);
    wait_e(1'h0);
    param_mode_in = m;
    reg_select_in = a;
    read_not_write_in = r;
    cpu_bus = d;
    cpu_en = !r;
    param_chip_select_n_in = 1'h0;
    if (r) exp_q.push_back({2'h1, 22'h0, d});
    wait_e(1'h1);
    wait_e(1'h0);
    param_chip_select_n_in = 1'h1;
    cpu_en = 1'h0;
  endtask

  // processor memory access; strobe and bus lines 5, 6 worked out from the page code
  task automatic mem_acc(input logic ps, input logic a0, input logic [2:0] c);
    logic pr;
    pr = ps | c[2];
    wait_e(1'h1);
    wait_e(1'h0);
    program_space_select_in = ps;
    reg_select_in = {1'h0, a0};
    read_not_write_in = 1'(rnd());
    memory_chip_select_n_in = 1'h0;
    exp_q.push_back({2'h2, 25'h0, pr | a0, pr | !a0, !pr,
                     pr ? {ps, a0} : c[1:0]});
    wait_e(1'h1);
    wait_e(1'h0);
    memory_chip_select_n_in = 1'h1;
  endtask

  // dma byte; address is pointer over a wrapping five bit count
  task automatic send_byte();
    logic [7:0] b;
    b = 8'(rnd());
    exp_q.push_back({2'h3, 9'h0, ptr, low, b});
    {ptr, low} = {ptr, low} + 13'h0001;
    vdad_prefix_model_inst.send(b);
  endtask

  // blanking from the genlocked raster clears the dma address
  task automatic blank();
    horiz_blank_in = 1'h1;
    repeat (3) tick();
    horiz_blank_in = 1'h0;
    ptr = 8'h00;
    low = 5'h00;
  endtask

  task automatic got(input logic [31:0] v);
    if (exp_q.size() == 0) begin
      n_mismatch++;
      $display("unexpected at %0t: stray result %h", $time, v);
    end else check(v, exp_q.pop_front());
  endtask

  // result watcher, one note per first cycle of a result
  always @(negedge clock_in) begin
    rd = muxed_addr_data_bus_oe_out === 8'hFF && dma_ack_output_enable_n_out === 1'h1;
    mm = muxed_addr_data_bus_oe_out === 8'h60;
    dm = write_strobe_n_out === 1'h0 && dma_ack_output_enable_n_out === 1'h0;
    if (rd && !rd_q) got({2'h1, 22'h0, muxed_addr_data_bus_out});
    if (mm && !mm_q && mem_chk) got({2'h2, 25'h0, video_col_strobe_lo_n_out,
      video_col_strobe_hi_n_out, program_col_strobe_n_out, muxed_addr_data_bus_out[6:5]});
    if (dm && !dm_q) got({2'h3, 9'h0, dram_addr_out, muxed_addr_data_bus_out});
    rd_q = rd;
    mm_q = mm;
    dm_q = dm;
  end

  // main sequence
  initial begin
    repeat (4) tick();
    reg_acc(`VDAD_MODE_POINTER, `VDAD_REG_STATUS, 1'h1, 8'h00);
    reg_acc(`VDAD_MODE_POINTER, `VDAD_REG_POINTER, 1'h1, 8'h00);
    drain();
    $display("test reset values done");
    // every page code, unused bits set, all space and a0 pairs
    for (int c = 0; c < 5; c++) begin
      reg_acc(`VDAD_MODE_PAGE, `VDAD_REG_PAGE, 1'h0, {5'h1F, 3'(c)});
      reg_acc(`VDAD_MODE_SCROLL, `VDAD_REG_STATUS, 1'h1, {5'h00, 3'(c)});
      for (int k = 0; k < 4; k++) mem_acc(k[1], k[0], 3'(c));
    end
    drain();
    $display("test page routing done");
    // scroll at the top value and random ones
    for (int n = 0; n < 6; n++) begin
      s = (n == 0) ? `VDAD_SCROLL_MAX : 8'(rnd() % `VDAD_IMAGE_ROWS);
      reg_acc(`VDAD_MODE_SCROLL, `VDAD_REG_SCROLL, 1'h0, s);
      graphics_line_in = (n == 1) ? 8'hD1 : 8'(rnd() % `VDAD_IMAGE_ROWS);
      repeat (3) tick();
      check(fetch_row_out, 8'((s + graphics_line_in) % `VDAD_IMAGE_ROWS));
    end
    reg_acc(`VDAD_MODE_PAGE, `VDAD_REG_STATUS, 1'h1, 8'h04);
    drain();
    $display("test scroll done");
    // pointer load, a write in the wrong mode, readback
    reg_acc(`VDAD_MODE_PAGE, `VDAD_REG_PAGE, 1'h0, 8'h03);
    blank();
    reg_acc(`VDAD_MODE_POINTER, `VDAD_REG_POINTER, 1'h0, 8'hA5);
    reg_acc(`VDAD_MODE_PAGE, `VDAD_REG_POINTER, 1'h0, 8'h3C);
    reg_acc(`VDAD_MODE_POINTER, `VDAD_REG_POINTER, 1'h1, 8'hA5);
    ptr = 8'hA5;
    // processor holds the memory so the buffer fills until it refuses
    mem_chk = 1'h0;
    memory_chip_select_n_in = 1'h0;
    for (int i = 0; i < 24 && dma_fifo_ready_out === 1'h1; i++) send_byte();
    check(dma_fifo_ready_out, 1'h0);
    tick();
    memory_chip_select_n_in = 1'h1;
    drain();
    mem_chk = 1'h1;
    // further bytes cross the five bit wrap
    for (int i = 0; i < 20; i++) send_byte();
    drain();
    reg_acc(`VDAD_MODE_POINTER, `VDAD_REG_POINTER, 1'h1, ptr);
    reg_acc(`VDAD_MODE_PAGE, `VDAD_REG_STATUS, 1'h1, 8'h03);
    blank();
    reg_acc(`VDAD_MODE_POINTER, `VDAD_REG_POINTER, 1'h1, 8'h00);
    send_byte();
    drain();
    $display("test dma done");
    final_report();
  end
endmodule
